// ### hw/pfcp_pkg.sv
package pfcp_pkg;
	localparam int NCH = 6;

	// Register byte offsets
	localparam logic [3:0] REG_ENABLE = 4'h0;
	localparam logic [3:0] REG_MODE = 4'h4;
	localparam logic [3:0] REG_POLARITY = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hC;
	localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

	// Reset values
	localparam logic [5:0] RST_ENABLE = 6'h00;
	localparam logic [5:0] RST_MODE = 6'h00;
	localparam logic [5:0] RST_POLARITY = 6'h00;

	// Status layout: faults in low bits, alarm above
	localparam int STAT_FAULT_LSB = 0;
	localparam int STAT_ALARM_BIT = 8;

	// Blink timing
	localparam int CLK_HZ = 10_000_000;
	localparam int BLINK_HALF_MS = 250;
	localparam int MS_PER_S = 1000;
	localparam int BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / MS_PER_S);

	// Timing input selection per channel, two bits each, channel 1 lowest
	localparam logic [1:0] TSEL_COMMON = 2'h0;
	localparam logic [1:0] TSEL_FIRST = 2'h1;
	localparam logic [1:0] TSEL_SECOND = 2'h2;
	localparam logic [11:0] TIMING_MAP = {TSEL_SECOND, TSEL_SECOND, TSEL_FIRST,
		TSEL_COMMON, TSEL_COMMON, TSEL_COMMON};

	// Mode identities: bit0 = first mode, bit1 = second mode of each channel
	localparam logic [3:0] MODE_PAIR_FIRST = 4'h1;
	localparam logic [3:0] MODE_PAIR_SECOND = 4'h2;
	localparam logic MODE_A_SIDE = 1'b0;
	localparam logic POL_A = 1'b0;
	localparam logic POL_B = 1'b1;

	typedef struct packed {
		logic read;
		logic write;
		logic [3:0] address;
		logic [31:0] writedata;
	} pfcp_avreq_s;

	typedef struct packed {
		logic green;
		logic red;
		logic pol_a;
		logic pol_b;
		logic mode_second;
		logic sensor;
		logic passage;
		logic timing;
	} pfcp_lamp_s;
endpackage

// ### hw/pfcp_rise.sv
`timescale 1ns/10ps
module pfcp_rise #(
	parameter int W = 7
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_level,
	output logic [W-1:0] o_rise
);
	logic [W-1:0] prev_ff;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			prev_ff <= '0;
		end else begin
			prev_ff <= i_level;
		end
	end

	// One pulse per press, held buttons do not repeat
	assign o_rise = i_level & ~prev_ff;
endmodule

// ### hw/pfcp_panel.sv
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
module pfcp_panel #(
	parameter int BLINK_HALF_CYC = pfcp_pkg::BLINK_HALF_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [5:0] i_btn_toggle,
	input wire logic i_btn_monitor,
	input wire logic i_btn_reset,
	input wire logic i_op_inhibit,
	input wire logic [5:0] i_fault_event,
	input wire logic [5:0] i_sensor,
	input wire logic [5:0] i_passage_flag,
	input wire logic [5:0] i_passage_used,
	input wire logic i_timing_input_first,
	input wire logic i_timing_input_second,
	input wire logic i_timing_input_common,
	input wire pfcp_pkg::pfcp_avreq_s i_av,
	output logic [31:0] o_av_readdata,
	output logic o_av_waitrequest,
	output pfcp_pkg::pfcp_lamp_s [5:0] o_lamp,
	output logic [5:0] o_stop,
	output logic o_alarm
);
	localparam int BW = $clog2(BLINK_HALF_CYC + 1);

	logic [5:0] en_ff;
	logic [5:0] mode_ff;
	logic [5:0] pol_ff;
	logic [5:0] fault_ff;
	logic alarm_ff;
	logic blink_ff;
	logic [BW-1:0] blink_cnt_ff;
	logic ack_ff;
	logic [31:0] rdata_ff;
	pfcp_pkg::pfcp_lamp_s [5:0] lamp_ff;

	logic [5:0] nxt_en;
	logic [5:0] nxt_mode;
	logic [5:0] nxt_pol;
	logic [5:0] nxt_fault;
	logic nxt_blink;
	logic [BW-1:0] nxt_blink_cnt;
	logic [31:0] nxt_rdata;
	pfcp_pkg::pfcp_lamp_s [5:0] nxt_lamp;

	wire [6:0] rise;
	wire [5:0] tog_press;
	wire rst_press;
	wire [5:0] en_flip;
	wire [5:0] mode_flip;
	wire [5:0] pol_flip;
	wire req;
	wire wr_done;
	wire wr_enable;
	wire wr_mode;
	wire wr_pol;
	wire rd_first;
	wire blink_wrap;
	wire [31:0] status_word;

	function automatic logic timing_of(input logic [1:0] sel, input logic t_first,
		input logic t_second, input logic t_common);
		logic r;
		r = t_common;
		if (sel == pfcp_pkg::TSEL_FIRST) begin
			r = t_first;
		end else if (sel == pfcp_pkg::TSEL_SECOND) begin
			r = t_second;
		end
		return r;
	endfunction

	function automatic logic sensor_active(input logic raw, input logic pol);
		// Polarity B inverts the raw contact sense
		return raw ^ (pol == pfcp_pkg::POL_B);
	endfunction

	function automatic pfcp_pkg::pfcp_lamp_s lamp_of(input logic en, input logic fault,
		input logic mode, input logic pol, input logic sens, input logic pass,
		input logic used, input logic tim, input logic blink);
		pfcp_pkg::pfcp_lamp_s l;
		l.green = en & ~fault;
		l.red = fault & blink;
		l.pol_a = en & (pol == pfcp_pkg::POL_A);
		l.pol_b = en & (pol == pfcp_pkg::POL_B);
		l.mode_second = mode;
		l.sensor = sensor_active(sens, pol);
		l.passage = pass & used;
		l.timing = tim;
		return l;
	endfunction

	pfcp_rise #(
		.W(7)
	) u_rise (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_level({i_btn_reset, i_btn_toggle}),
		.o_rise(rise)
	);

	assign tog_press = rise[5:0] & {6{~i_op_inhibit}};
	assign rst_press = rise[6];
	assign en_flip = tog_press & {6{~i_btn_monitor & ~i_btn_reset}};
	assign mode_flip = tog_press & {6{i_btn_monitor}};
	assign pol_flip = tog_press & {6{i_btn_reset}};

	// Bus: one wait cycle, then answer
	assign req = i_av.read | i_av.write;
	assign o_av_waitrequest = req & ~ack_ff;
	assign wr_done = i_av.write & ack_ff;
	assign rd_first = i_av.read & ~ack_ff;
	assign wr_enable = wr_done & (i_av.address == pfcp_pkg::REG_ENABLE);
	assign wr_mode = wr_done & (i_av.address == pfcp_pkg::REG_MODE);
	assign wr_pol = wr_done & (i_av.address == pfcp_pkg::REG_POLARITY);

	// Panel press lands after a same-cycle bus write
	assign nxt_en = (wr_enable ? i_av.writedata[5:0] : en_ff) ^ en_flip;
	assign nxt_mode = (wr_mode ? i_av.writedata[5:0] : mode_ff) ^ mode_flip;
	assign nxt_pol = (wr_pol ? i_av.writedata[5:0] : pol_ff) ^ pol_flip;

	assign nxt_fault = (fault_ff & {6{~rst_press}}) | (i_fault_event & en_ff);

	assign status_word = (32'(fault_ff) << pfcp_pkg::STAT_FAULT_LSB)
		| (32'(alarm_ff) << pfcp_pkg::STAT_ALARM_BIT);
	assign nxt_rdata = (i_av.address == pfcp_pkg::REG_ENABLE) ? 32'(en_ff) :
		(i_av.address == pfcp_pkg::REG_MODE) ? 32'(mode_ff) :
		(i_av.address == pfcp_pkg::REG_POLARITY) ? 32'(pol_ff) :
		(i_av.address == pfcp_pkg::REG_STATUS) ? status_word : pfcp_pkg::RD_UNMAPPED;

	assign blink_wrap = blink_cnt_ff == BW'(BLINK_HALF_CYC - 1);
	assign nxt_blink_cnt = blink_wrap ? '0 : blink_cnt_ff + BW'(1);
	assign nxt_blink = blink_wrap ? ~blink_ff : blink_ff;

	genvar g;
	generate
		for (g = 0; g < pfcp_pkg::NCH; g++) begin : g_ch
			assign nxt_lamp[g] = lamp_of(nxt_en[g], nxt_fault[g], nxt_mode[g], nxt_pol[g],
				i_sensor[g], i_passage_flag[g], i_passage_used[g],
				timing_of(pfcp_pkg::TIMING_MAP[2*g +: 2], i_timing_input_first,
				i_timing_input_second, i_timing_input_common), nxt_blink);
		end
	endgenerate

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			en_ff <= pfcp_pkg::RST_ENABLE;
			mode_ff <= pfcp_pkg::RST_MODE;
			pol_ff <= pfcp_pkg::RST_POLARITY;
			fault_ff <= '0;
			alarm_ff <= 1'b0;
		end else begin
			en_ff <= nxt_en;
			mode_ff <= nxt_mode;
			pol_ff <= nxt_pol;
			fault_ff <= nxt_fault;
			alarm_ff <= |nxt_fault;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			blink_cnt_ff <= '0;
			blink_ff <= 1'b0;
			lamp_ff <= '0;
		end else begin
			blink_cnt_ff <= nxt_blink_cnt;
			blink_ff <= nxt_blink;
			lamp_ff <= nxt_lamp;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ack_ff <= 1'b0;
			rdata_ff <= '0;
		end else begin
			ack_ff <= req & ~ack_ff;
			if (rd_first) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	assign o_av_readdata = rdata_ff;
	assign o_lamp = lamp_ff;
	assign o_stop = fault_ff;
	assign o_alarm = alarm_ff;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	generate
		for (g = 0; g < pfcp_pkg::NCH; g++) begin : g_chk
			property p_green_on;
				en_ff[g] && !fault_ff[g] |-> o_lamp[g].green && !o_lamp[g].red;
			endproperty
			a_green_on: assert property (p_green_on) else $error("green lamp missing");

			property p_dark_off;
				!en_ff[g] && !fault_ff[g] |-> !o_lamp[g].green && !o_lamp[g].red;
			endproperty
			a_dark_off: assert property (p_dark_off) else $error("lamp lit while off");

			property p_fault_blink;
				$rose(fault_ff[g]) |-> !o_lamp[g].green && o_lamp[g].red == blink_ff;
			endproperty
			a_fault_blink: assert property (p_fault_blink) else $error("no red blink");

			property p_red_stops;
				o_lamp[g].red |-> o_stop[g];
			endproperty
			a_red_stops: assert property (p_red_stops) else $error("red without stop");

			sequence s_stop_no_reset;
				o_stop[g] && !rst_press;
			endsequence
			sequence s_reset_clean;
				rst_press && !(i_fault_event[g] && en_ff[g]);
			endsequence
			property p_stop_hold;
				s_stop_no_reset |=> o_stop[g];
			endproperty
			a_stop_hold: assert property (p_stop_hold) else $error("stop dropped early");
			property p_stop_release;
				s_reset_clean |=> !o_stop[g] && !o_lamp[g].red;
			endproperty
			a_stop_release: assert property (p_stop_release) else $error("stop kept");

			property p_toggle;
				i_btn_toggle[g] && !$past(i_btn_toggle[g]) && !i_op_inhibit && !i_btn_monitor
					&& !i_btn_reset && !wr_enable |=> en_ff[g] != $past(en_ff[g]);
			endproperty
			a_toggle: assert property (p_toggle) else $error("enable not toggled");

			property p_mode;
				mode_flip[g] && !wr_mode |=> mode_ff[g] != $past(mode_ff[g])
					&& o_lamp[g].mode_second == mode_ff[g];
			endproperty
			a_mode: assert property (p_mode) else $error("mode not swapped");

			property p_pol;
				pol_flip[g] && !wr_pol |=> pol_ff[g] != $past(pol_ff[g]);
			endproperty
			a_pol: assert property (p_pol) else $error("polarity not swapped");

			property p_pol_lamp;
				o_lamp[g].pol_a + o_lamp[g].pol_b == 2'(en_ff[g])
					&& (!en_ff[g] || o_lamp[g].pol_b == pol_ff[g]);
			endproperty
			a_pol_lamp: assert property (p_pol_lamp) else $error("polarity lamp wrong");

			property p_sense;
				##1 o_lamp[g].sensor == ($past(i_sensor[g]) ^ pol_ff[g]);
			endproperty
			a_sense: assert property (p_sense) else $error("input lamp wrong");

			property p_modifier;
				tog_press[g] && (i_btn_monitor || i_btn_reset) && !wr_enable
					|=> $stable(en_ff[g]);
			endproperty
			a_modifier: assert property (p_modifier) else $error("modifier toggled");

			property p_inhibit;
				i_op_inhibit && !wr_enable && !wr_mode && !wr_pol
					|=> $stable(en_ff[g]) && $stable(mode_ff[g]) && $stable(pol_ff[g]);
			endproperty
			a_inhibit: assert property (p_inhibit) else $error("inhibit ignored");

			// Every channel, not only the sampled one
			property p_passage_all;
				##1 o_lamp[g].passage == ($past(i_passage_flag[g]) && $past(i_passage_used[g]));
			endproperty
			a_passage_all: assert property (p_passage_all) else $error("passage lamp off");
		end
	endgenerate

	property p_timing_map;
		##1 o_lamp[0].timing == $past(i_timing_input_common)
			&& o_lamp[3].timing == $past(i_timing_input_first)
			&& o_lamp[5].timing == $past(i_timing_input_second);
	endproperty
	a_timing_map: assert property (p_timing_map) else $error("timing lamp wrong");

	// Remaining channels follow their own input
	property p_timing_rest;
		##1 o_lamp[1].timing == $past(i_timing_input_common)
			&& o_lamp[2].timing == $past(i_timing_input_common)
			&& o_lamp[4].timing == $past(i_timing_input_second);
	endproperty
	a_timing_rest: assert property (p_timing_rest) else $error("timing lamp stale");

	property p_alarm;
		o_alarm == (|o_stop);
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm not with stop");

	property p_passage;
		##1 o_lamp[1].passage == ($past(i_passage_flag[1]) && $past(i_passage_used[1]));
	endproperty
	a_passage: assert property (p_passage) else $error("passage lamp wrong");
endmodule

// ### verif/pfcp_press.sv
`timescale 1ns/10ps
module pfcp_press (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [5:0] i_stop,
	input wire logic [2:0] i_req,
	output logic o_t_first,
	output logic o_t_second,
	output logic o_t_common
);
	logic halted_ff;
	// A stopped press makes no timing strokes
	always_ff @(posedge i_clk) begin
		halted_ff <= i_rst ? 1'b0 : (|i_stop);
	end
	assign o_t_first = i_req[0] & ~halted_ff;
	assign o_t_second = i_req[1] & ~halted_ff;
	assign o_t_common = i_req[2] & ~halted_ff;
endmodule

// ### verif/pfcp_panel_tb.sv
`timescale 1ns/10ps
module pfcp_panel_tb;
	localparam int HALF = 4;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [5:0] tog = '0, flt = '0, sens = '0, pflag = '0, pused = '0, stop;
	logic mon = 1'b0, rbtn = 1'b0, inh = 1'b0;
	logic [2:0] treq = '0;
	pfcp_pkg::pfcp_avreq_s av = '0;
	logic [31:0] rdata, rd_q, v;
	logic wreq, wait_q, t_first, t_second, t_common, alarm, exp_t;
	pfcp_pkg::pfcp_lamp_s [5:0] lamp;
	int num_errors = 0;
	int checked = 0;
	int nred, ngrn;

	always #50 i_clk = ~i_clk;
	// Snapshot before each rising edge, so bus sampling never races the edge
	always @(negedge i_clk) begin
		wait_q = wreq;
		rd_q = rdata;
	end

	pfcp_panel #(.BLINK_HALF_CYC(HALF)) dut (.i_clk(i_clk), .i_rst(i_rst),
		.i_btn_toggle(tog), .i_btn_monitor(mon), .i_btn_reset(rbtn), .i_op_inhibit(inh),
		.i_fault_event(flt), .i_sensor(sens), .i_passage_flag(pflag), .i_passage_used(pused),
		.i_timing_input_first(t_first), .i_timing_input_second(t_second),
		.i_timing_input_common(t_common), .i_av(av), .o_av_readdata(rdata),
		.o_av_waitrequest(wreq), .o_lamp(lamp), .o_stop(stop), .o_alarm(alarm));
	pfcp_press press_model (.i_clk(i_clk), .i_rst(i_rst), .i_stop(stop), .i_req(treq),
		.o_t_first(t_first), .o_t_second(t_second), .o_t_common(t_common));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Waits as long as the slave asks; only the watchdog ends a hang
	task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
		@(posedge i_clk);
		av <= '{read: ~wr, write: wr, address: adr, writedata: wd};
		do begin
			@(posedge i_clk);
		end while (wait_q);
		v = rd_q;
		av <= '0;
	endtask

	task automatic rd(input logic [3:0] adr, input logic [31:0] exp);
		bus(1'b0, adr, 32'h0);
		chk(v, exp);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge i_clk);
		@(negedge i_clk);
	endtask

	task automatic press(input logic [5:0] m, input logic mo, input logic rb);
		@(posedge i_clk);
		mon <= mo;
		rbtn <= rb;
		@(posedge i_clk);
		tog <= m;
		@(posedge i_clk);
		tog <= '0;
		@(posedge i_clk);
		mon <= 1'b0;
		rbtn <= 1'b0;
		settle(1);
	endtask

	function automatic logic [31:0] lmp(input int k);
		return {24'h0, lamp[k]};
	endfunction

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge i_clk);
		num_errors++;
		print_verdict();
	end

	initial begin
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(pfcp_pkg::REG_ENABLE, 32'h0);
		rd(4'h2, pfcp_pkg::RD_UNMAPPED);
		chk(lmp(0), 32'h0);
		$display("test reset done");
		press(6'h01, 1'b0, 1'b0);
		chk(lmp(0), 32'hA0);
		rd(pfcp_pkg::REG_ENABLE, 32'h1);
		press(6'h01, 1'b0, 1'b0);
		chk(lmp(0), 32'h0);
		@(posedge i_clk);
		inh <= 1'b1;
		press(6'h04, 1'b0, 1'b0);
		rd(pfcp_pkg::REG_ENABLE, 32'h0);
		inh <= 1'b0;
		$display("test toggle done");
		bus(1'b1, pfcp_pkg::REG_ENABLE, 32'h3F);
		press(6'h02, 1'b1, 1'b0);
		rd(pfcp_pkg::REG_MODE, 32'h2);
		rd(pfcp_pkg::REG_ENABLE, 32'h3F);
		press(6'h02, 1'b0, 1'b1);
		rd(pfcp_pkg::REG_POLARITY, 32'h2);
		rd(pfcp_pkg::REG_ENABLE, 32'h3F);
		chk(lmp(1), 32'h9C);
		sens <= 6'h03;
		settle(2);
		chk(lmp(1), 32'h98);
		chk(lmp(0), 32'hA4);
		@(posedge i_clk);
		sens <= 6'h02;
		$display("test modifiers done");
		// Channels 1-3 common, 4 first, 5-6 second
		for (int i = 0; i < 3; i++) begin
			@(posedge i_clk);
			treq <= 3'(1 << i);
			settle(3);
			for (int k = 0; k < 6; k++) begin
				exp_t = (k < 3) ? i == 2 : (k == 3) ? i == 0 : i == 1;
				chk({31'h0, lamp[k].timing}, {31'h0, exp_t});
			end
		end
		@(posedge i_clk);
		treq <= 3'h0;
		pflag <= 6'h3F;
		pused <= 6'h3F;
		settle(2);
		chk({31'h0, lamp[5].passage}, 32'h1);
		chk({31'h0, lamp[2].timing}, 32'h0);
		$display("test status lamps done");
		bus(1'b1, pfcp_pkg::REG_ENABLE, 32'h3B);
		bus(1'b1, pfcp_pkg::REG_STATUS, 32'h1FF);
		@(posedge i_clk);
		flt <= 6'h06;
		@(posedge i_clk);
		flt <= 6'h00;
		settle(1);
		chk({26'h0, stop}, 32'h2);
		chk({31'h0, alarm}, 32'h1);
		rd(pfcp_pkg::REG_STATUS, 32'h102);
		nred = 0;
		ngrn = 0;
		repeat (2 * HALF) begin
			@(negedge i_clk);
			nred += int'(lamp[1].red);
			ngrn += int'(lamp[1].green);
		end
		chk(nred, HALF);
		chk(ngrn, 0);
		press(6'h00, 1'b0, 1'b1);
		chk({26'h0, stop}, 32'h0);
		chk({31'h0, alarm}, 32'h0);
		rd(pfcp_pkg::REG_STATUS, 32'h0);
		$display("test fault done");
		print_verdict();
	end
endmodule
